// ==== core/cbqm_fifo.sv ====
/*
  cbqm_fifo: one buffer-identifier queue held in flip-flops, with a live
  occupancy count. Assumes a single pusher and a single popper, both on
  the system clock; a push to a full queue without a pop is dropped.
*/
`timescale 1ns/100ps
module cbqm_fifo
  import cbqm_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              push_i,
  input  wire logic [ID_W-1:0]   din_i,
  input  wire logic              pop_i,
  output logic      [ID_W-1:0]   dout_o,
  output logic      [LVL_W-1:0]  count_o
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][ID_W-1:0] mem;
    logic [PW-1:0]              wp;
    logic [PW-1:0]              rp;
    logic [PW:0]                cnt;
  } cbqm_fifo_t;

  cbqm_fifo_t st_r;
  cbqm_fifo_t st_nxt;
  logic       do_pop;
  logic       do_push;

  always_comb begin
    st_nxt  = st_r;
    do_pop  = pop_i && (st_r.cnt != '0);
    do_push = push_i && ((st_r.cnt != (PW+1)'(DEPTH)) || do_pop);
    if (do_push) begin
      st_nxt.mem[st_r.wp] = din_i;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    // level follows every accepted insert and extract
    if (do_push && !do_pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout_o  = st_r.mem[st_r.rp];
  assign count_o = LVL_W'(st_r.cnt);

endmodule

// ==== core/cbqm_pkg.sv ====
/*
  cbqm_pkg: constants and state type shared by the buffer/queue manager
  and its queue module. Assumes an 18-bit host register address with the
  queue block and the transmit linked-list block at fixed bases.
*/
package cbqm_pkg;

  // ------------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------------
  localparam int             HADDR_W     = 18;
  localparam int             ID_W        = 13;
  localparam int             SDRAM_AW    = 24;
  localparam int             TXID_W      = 9;
  localparam int             TXBASE_W    = SDRAM_AW - TXID_W - 11;
  localparam int             LVL_W       = 8;
  localparam int             SHALLOW_W   = 6;
  localparam int             DEEP_DEPTH  = 128;
  localparam int             SHALLOW_DEPTH = 32;
  localparam int             N_BUNDLE    = 64;
  localparam int             N_TXBUF     = 512;
  localparam int             HEAD_VALID_BIT = 9;
  localparam int             NQ          = 6;
  localparam logic [10:0]    LOW_ZEROS   = 11'h000;

  // queue index; the two deep queues come first
  localparam int             Q_RXPOOL    = 0;
  localparam int             Q_HOSTQ     = 1;
  localparam int             Q_ETHO      = 2;
  localparam int             Q_LINE      = 3;
  localparam int             Q_SENT      = 4;
  localparam int             Q_RECV      = 5;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [17:0]    QUEUE_BASE  = 18'h20000;
  localparam logic [17:0]    LIST_BASE   = 18'h28000;
  localparam logic [17:0]    HEAD_BASE   = LIST_BASE + 18'h00800;
  localparam logic [17:0]    ALT16_STEP  = 18'h00002;

  localparam logic [17:0]    OFS_ETHO_INS  = 18'h00018;
  localparam logic [17:0]    OFS_ETHO_LVL  = 18'h0001C;
  localparam logic [17:0]    OFS_ETHO_THR  = 18'h00020;
  localparam logic [17:0]    OFS_POOL_INS  = 18'h00024;
  localparam logic [17:0]    OFS_POOL_LVL  = 18'h00028;
  localparam logic [17:0]    OFS_POOL_THR  = 18'h0002C;
  localparam logic [17:0]    OFS_HOSTQ_POP = 18'h00030;
  localparam logic [17:0]    OFS_HOSTQ_LVL = 18'h00034;
  localparam logic [17:0]    OFS_HOSTQ_THR = 18'h00038;
  localparam logic [17:0]    OFS_CHANGE    = 18'h00040;
  localparam logic [17:0]    OFS_MASK      = 18'h00044;
  localparam logic [17:0]    OFS_LINE_INS  = 18'h00054;
  localparam logic [17:0]    OFS_LINE_LVL  = 18'h00058;
  localparam logic [17:0]    OFS_LINE_THR  = 18'h0005C;
  localparam logic [17:0]    OFS_SENT_POP  = 18'h00060;
  localparam logic [17:0]    OFS_SENT_LVL  = 18'h00064;
  localparam logic [17:0]    OFS_SENT_THR  = 18'h00068;
  localparam logic [17:0]    OFS_RECV_POP  = 18'h0006C;
  localparam logic [17:0]    OFS_RECV_LVL  = 18'h00070;
  localparam logic [17:0]    OFS_RECV_THR  = 18'h00074;

  // reset values
  localparam logic [LVL_W-1:0]     RST_THR_DEEP    = 8'h00;
  localparam logic [SHALLOW_W-1:0] RST_THR_SHALLOW = 6'h00;
  localparam logic [NQ-1:0]        RST_MASK        = 6'h00;

  // ------------------------------------------------------------------
  // state of the manager
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                         rdata;
    logic                                irq;
    logic [LVL_W-1:0]                    pool_thr;
    logic [LVL_W-1:0]                    hostq_thr;
    logic [SHALLOW_W-1:0]                etho_thr;
    logic [SHALLOW_W-1:0]                line_thr;
    logic [SHALLOW_W-1:0]                sent_thr;
    logic [SHALLOW_W-1:0]                recv_thr;
    logic [NQ-1:0]                       chg;
    logic [NQ-1:0]                       mask;
    logic [NQ-1:0]                       cond;
    logic                                rxb_vld;
    logic [SDRAM_AW-1:0]                 rxb_addr;
    logic                                etx_vld;
    logic [SDRAM_AW-1:0]                 etx_addr;
    logic                                line_vld;
    logic [SDRAM_AW-1:0]                 line_addr;
    logic                                drop;
    logic [ID_W-1:0]                     drop_id;
    logic                                head_valid;
    logic [SDRAM_AW-1:0]                 head_addr;
    logic [SDRAM_AW-1:0]                 next_addr;
    logic [N_BUNDLE-1:0][TXID_W:0]       heads;
    logic [N_TXBUF-1:0][TXID_W-1:0]      nexts;
  } cbqm_state_t;

endpackage

// ==== core/cbqm_queue_manager.sv ====
/*
  cbqm_queue_manager: host buffer pools and queues plus the transmit
  linked-list memory. Assumes a simple synchronous host register port
  (address, one-cycle read and write strobes) and packet engines that
  pulse their take and push requests on the system clock.
*/
`timescale 1ns/100ps

// Overview of operation
// - pool insert write adds one identifier from write bits 12..0.
// - every queue identifier is SDRAM address bits 23..11.
// - eth-out queue alarm when level is at or below its threshold.
// - pool level register shows buffers left for the receive arbiter.
// - low pool alarms and lets only OAM packets into the host queue.
// - host queue pop read returns oldest identifier and removes it.
// - host queue alarm when level is at or above its threshold.
// - line-out insert write appends identifier from write bits 12..0.
// - line-out, sent and received return queues alarm at level >= threshold.
// - shallow queues report occupancy in a 6-bit level field.
// - sent-return pop read returns and removes oldest identifier.
// - received-return pop read returns and removes oldest identifier.
// - 64 bundle heads, bit 9 marks a valid free buffer.
// - transmit address is base, 9-bit identifier, eleven zeros.
// - 512 next-pointer entries link each bundle's buffers.
// - linked-list memory decodes at register base 0x28000.
// - threshold crossing latches a change bit driving irq unless masked.
// - in 16-bit host mode queue registers sit two bytes higher.
module cbqm_queue_manager
  import cbqm_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 srst_i,
  input  wire logic                 host_bus_width_select_i,
  input  wire logic [HADDR_W-1:0]   host_addr_i,
  input  wire logic                 host_wr_i,
  input  wire logic                 host_rd_i,
  input  wire logic [31:0]          host_wdata_i,
  output logic      [31:0]          host_rdata_o,
  output logic                      irq_o,
  input  wire logic                 rx_buf_take_i,
  output logic                      rx_buf_valid_o,
  output logic      [SDRAM_AW-1:0]  rx_buf_addr_o,
  input  wire logic                 rx_pkt_push_i,
  input  wire logic [ID_W-1:0]      rx_pkt_id_i,
  input  wire logic                 rx_pkt_oam_i,
  output logic                      rx_pkt_drop_o,
  output logic      [ID_W-1:0]      rx_pkt_drop_id_o,
  input  wire logic                 eth_tx_take_i,
  output logic                      eth_tx_valid_o,
  output logic      [SDRAM_AW-1:0]  eth_tx_addr_o,
  input  wire logic                 line_tx_take_i,
  output logic                      line_tx_valid_o,
  output logic      [SDRAM_AW-1:0]  line_tx_addr_o,
  input  wire logic                 sent_ret_push_i,
  input  wire logic [ID_W-1:0]      sent_ret_id_i,
  input  wire logic                 recv_ret_push_i,
  input  wire logic [ID_W-1:0]      recv_ret_id_i,
  input  wire logic [TXBASE_W-1:0]  tx_buf_base_i,
  input  wire logic [5:0]           tx_bundle_i,
  input  wire logic [TXID_W-1:0]    tx_buf_i,
  output logic                      tx_head_valid_o,
  output logic      [SDRAM_AW-1:0]  tx_head_addr_o,
  output logic      [SDRAM_AW-1:0]  tx_next_addr_o
);

  // ------------------------------------------------------------------
  // queues
  // ------------------------------------------------------------------
  cbqm_state_t                st_r;
  cbqm_state_t                st_nxt;
  logic [NQ-1:0]              q_push;
  logic [NQ-1:0]              q_pop;
  logic [NQ-1:0][ID_W-1:0]    q_din;
  logic [NQ-1:0][ID_W-1:0]    q_dout;
  logic [NQ-1:0][LVL_W-1:0]   q_cnt;

  for (genvar gi = 0; gi < NQ; gi++) begin : g_q
    cbqm_fifo #(
      .DEPTH (gi < 2 ? DEEP_DEPTH : SHALLOW_DEPTH)
    ) u_fifo (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .push_i    (q_push[gi]),
      .din_i     (q_din[gi]),
      .pop_i     (q_pop[gi]),
      .dout_o    (q_dout[gi]),
      .count_o   (q_cnt[gi])
    );
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [SDRAM_AW-1:0] id_to_addr(input logic [ID_W-1:0] id);
    return {id, LOW_ZEROS};
  endfunction

  function automatic logic [SDRAM_AW-1:0] tx_addr(input logic [TXBASE_W-1:0] base,
                                                   input logic [TXID_W-1:0]   id);
    return {base, id, LOW_ZEROS};
  endfunction

  function automatic logic [31:0] shallow_word(input logic [LVL_W-1:0] lvl);
    return {26'h0000000, lvl[SHALLOW_W-1:0]};
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [HADDR_W-1:0] adj;
    logic [31:0]        rdv;
    logic [NQ-1:0]      cnow;
    logic [NQ-1:0]      clr;
    logic               is_next;
    logic               is_head;
    logic [TXID_W-1:0]  hid;
    adj     = '0;
    rdv     = '0;
    cnow    = '0;
    clr     = '0;
    is_next = 1'b0;
    is_head = 1'b0;
    hid     = '0;
    st_nxt  = st_r;
    q_push  = '0;
    q_pop   = '0;
    q_din   = '0;

    // low level on the select means a 16-bit host bus
    adj     = host_bus_width_select_i ? 18'h00000 : ALT16_STEP;
    is_next = (host_addr_i[17:11] == LIST_BASE[17:11]);
    is_head = (host_addr_i[17:8] == HEAD_BASE[17:8]);

    // host writes
    if (host_wr_i) begin
      unique case (host_addr_i)
        QUEUE_BASE + OFS_ETHO_INS + adj: begin
          q_push[Q_ETHO] = 1'b1;
          q_din[Q_ETHO]  = host_wdata_i[ID_W-1:0];
        end
        QUEUE_BASE + OFS_POOL_INS + adj: begin
          q_push[Q_RXPOOL] = 1'b1;
          q_din[Q_RXPOOL]  = host_wdata_i[ID_W-1:0];
        end
        QUEUE_BASE + OFS_LINE_INS + adj: begin
          q_push[Q_LINE] = 1'b1;
          q_din[Q_LINE]  = host_wdata_i[ID_W-1:0];
        end
        QUEUE_BASE + OFS_ETHO_THR + adj:  st_nxt.etho_thr  = host_wdata_i[SHALLOW_W-1:0];
        QUEUE_BASE + OFS_POOL_THR + adj:  st_nxt.pool_thr  = host_wdata_i[LVL_W-1:0];
        QUEUE_BASE + OFS_HOSTQ_THR + adj: st_nxt.hostq_thr = host_wdata_i[LVL_W-1:0];
        QUEUE_BASE + OFS_LINE_THR + adj:  st_nxt.line_thr  = host_wdata_i[SHALLOW_W-1:0];
        QUEUE_BASE + OFS_SENT_THR + adj:  st_nxt.sent_thr  = host_wdata_i[SHALLOW_W-1:0];
        QUEUE_BASE + OFS_RECV_THR + adj:  st_nxt.recv_thr  = host_wdata_i[SHALLOW_W-1:0];
        QUEUE_BASE + OFS_CHANGE + adj:    clr              = host_wdata_i[NQ-1:0];
        QUEUE_BASE + OFS_MASK + adj:      st_nxt.mask      = host_wdata_i[NQ-1:0];
        default: begin
          if (is_head) begin
            st_nxt.heads[host_addr_i[7:2]] = host_wdata_i[TXID_W:0];
          end else if (is_next) begin
            st_nxt.nexts[host_addr_i[10:2]] = host_wdata_i[TXID_W-1:0];
          end
        end
      endcase
    end

    // host reads; a pop read of an empty queue returns zero and pops nothing
    if (host_rd_i) begin
      unique case (host_addr_i)
        QUEUE_BASE + OFS_ETHO_LVL + adj:  rdv = shallow_word(q_cnt[Q_ETHO]);
        QUEUE_BASE + OFS_ETHO_THR + adj:  rdv = {26'h0000000, st_r.etho_thr};
        QUEUE_BASE + OFS_POOL_LVL + adj:  rdv = {24'h000000, q_cnt[Q_RXPOOL]};
        QUEUE_BASE + OFS_POOL_THR + adj:  rdv = {24'h000000, st_r.pool_thr};
        QUEUE_BASE + OFS_HOSTQ_POP + adj: begin
          q_pop[Q_HOSTQ] = (q_cnt[Q_HOSTQ] != '0);
          rdv = q_pop[Q_HOSTQ] ? {19'h00000, q_dout[Q_HOSTQ]} : 32'h00000000;
        end
        QUEUE_BASE + OFS_HOSTQ_LVL + adj: rdv = {24'h000000, q_cnt[Q_HOSTQ]};
        QUEUE_BASE + OFS_HOSTQ_THR + adj: rdv = {24'h000000, st_r.hostq_thr};
        QUEUE_BASE + OFS_CHANGE + adj:    rdv = {26'h0000000, st_r.chg};
        QUEUE_BASE + OFS_MASK + adj:      rdv = {26'h0000000, st_r.mask};
        QUEUE_BASE + OFS_LINE_LVL + adj:  rdv = shallow_word(q_cnt[Q_LINE]);
        QUEUE_BASE + OFS_LINE_THR + adj:  rdv = {26'h0000000, st_r.line_thr};
        QUEUE_BASE + OFS_SENT_POP + adj: begin
          q_pop[Q_SENT] = (q_cnt[Q_SENT] != '0);
          rdv = q_pop[Q_SENT] ? {19'h00000, q_dout[Q_SENT]} : 32'h00000000;
        end
        QUEUE_BASE + OFS_SENT_LVL + adj:  rdv = shallow_word(q_cnt[Q_SENT]);
        QUEUE_BASE + OFS_SENT_THR + adj:  rdv = {26'h0000000, st_r.sent_thr};
        QUEUE_BASE + OFS_RECV_POP + adj: begin
          q_pop[Q_RECV] = (q_cnt[Q_RECV] != '0);
          rdv = q_pop[Q_RECV] ? {19'h00000, q_dout[Q_RECV]} : 32'h00000000;
        end
        QUEUE_BASE + OFS_RECV_LVL + adj:  rdv = shallow_word(q_cnt[Q_RECV]);
        QUEUE_BASE + OFS_RECV_THR + adj:  rdv = {26'h0000000, st_r.recv_thr};
        default: begin
          if (is_head) begin
            rdv = {22'h000000, st_r.heads[host_addr_i[7:2]]};
          end else if (is_next) begin
            rdv = {23'h000000, st_r.nexts[host_addr_i[10:2]]};
          end
        end
      endcase
      st_nxt.rdata = rdv;
    end

    // ------------------------------------------------------------------
    // alarm conditions and latched change bits
    // ------------------------------------------------------------------
    cnow[Q_RXPOOL] = (q_cnt[Q_RXPOOL] <= st_r.pool_thr);
    cnow[Q_HOSTQ]  = (q_cnt[Q_HOSTQ] >= st_r.hostq_thr);
    cnow[Q_ETHO]   = (q_cnt[Q_ETHO][SHALLOW_W-1:0] <= st_r.etho_thr);
    cnow[Q_LINE]   = (q_cnt[Q_LINE][SHALLOW_W-1:0] >= st_r.line_thr);
    cnow[Q_SENT]   = (q_cnt[Q_SENT][SHALLOW_W-1:0] >= st_r.sent_thr);
    cnow[Q_RECV]   = (q_cnt[Q_RECV][SHALLOW_W-1:0] >= st_r.recv_thr);
    st_nxt.cond    = cnow;
    // a crossing in the clearing cycle still latches
    st_nxt.chg     = (st_r.chg & ~clr) | (cnow & ~st_r.cond);
    st_nxt.irq     = |(st_nxt.chg & ~st_nxt.mask);

    // ------------------------------------------------------------------
    // packet-engine side
    // ------------------------------------------------------------------
    q_pop[Q_RXPOOL] = rx_buf_take_i && (q_cnt[Q_RXPOOL] != '0);
    st_nxt.rxb_vld  = q_pop[Q_RXPOOL];
    if (q_pop[Q_RXPOOL]) begin
      st_nxt.rxb_addr = id_to_addr(q_dout[Q_RXPOOL]);
    end

    // a short pool starves ordinary traffic so OAM can still reach the host
    st_nxt.drop = rx_pkt_push_i && cnow[Q_RXPOOL] && !rx_pkt_oam_i;
    if (st_nxt.drop) begin
      st_nxt.drop_id = rx_pkt_id_i;
    end
    q_push[Q_HOSTQ] = rx_pkt_push_i && !st_nxt.drop;
    q_din[Q_HOSTQ]  = rx_pkt_id_i;

    q_pop[Q_ETHO]  = eth_tx_take_i && (q_cnt[Q_ETHO] != '0);
    st_nxt.etx_vld = q_pop[Q_ETHO];
    if (q_pop[Q_ETHO]) begin
      st_nxt.etx_addr = id_to_addr(q_dout[Q_ETHO]);
    end

    q_pop[Q_LINE]   = line_tx_take_i && (q_cnt[Q_LINE] != '0);
    st_nxt.line_vld = q_pop[Q_LINE];
    if (q_pop[Q_LINE]) begin
      st_nxt.line_addr = id_to_addr(q_dout[Q_LINE]);
    end

    q_push[Q_SENT] = sent_ret_push_i;
    q_din[Q_SENT]  = sent_ret_id_i;
    q_push[Q_RECV] = recv_ret_push_i;
    q_din[Q_RECV]  = recv_ret_id_i;

    // linked-list lookups; contents are only meaningful once software filled them
    hid               = st_r.heads[tx_bundle_i][TXID_W-1:0];
    st_nxt.head_valid = st_r.heads[tx_bundle_i][HEAD_VALID_BIT];
    st_nxt.head_addr  = tx_addr(tx_buf_base_i, hid);
    st_nxt.next_addr  = tx_addr(tx_buf_base_i, st_r.nexts[tx_buf_i]);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r           <= '0;
      st_r.pool_thr  <= RST_THR_DEEP;
      st_r.hostq_thr <= RST_THR_DEEP;
      st_r.etho_thr  <= RST_THR_SHALLOW;
      st_r.line_thr  <= RST_THR_SHALLOW;
      st_r.sent_thr  <= RST_THR_SHALLOW;
      st_r.recv_thr  <= RST_THR_SHALLOW;
      st_r.mask      <= RST_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata_o     = st_r.rdata;
  assign irq_o            = st_r.irq;
  assign rx_buf_valid_o   = st_r.rxb_vld;
  assign rx_buf_addr_o    = st_r.rxb_addr;
  assign rx_pkt_drop_o    = st_r.drop;
  assign rx_pkt_drop_id_o = st_r.drop_id;
  assign eth_tx_valid_o   = st_r.etx_vld;
  assign eth_tx_addr_o    = st_r.etx_addr;
  assign line_tx_valid_o  = st_r.line_vld;
  assign line_tx_addr_o   = st_r.line_addr;
  assign tx_head_valid_o  = st_r.head_valid;
  assign tx_head_addr_o   = st_r.head_addr;
  assign tx_next_addr_o   = st_r.next_addr;

endmodule

// ==== sim/cbqm_properties.sv ====
/* cbqm_properties: port checks on the queue manager.
   Assumes cbqm_pkg compiled first; bound into every instance. */
`timescale 1ns/100ps
module cbqm_properties
  import cbqm_pkg::*;
(
  input wire logic                clk_sys_i,
  input wire logic                srst_i,
  input wire logic                host_bus_width_select_i,
  input wire logic [HADDR_W-1:0]  host_addr_i,
  input wire logic                host_wr_i,
  input wire logic                host_rd_i,
  input wire logic [31:0]         host_wdata_i,
  input wire logic [31:0]         host_rdata_o,
  input wire logic                irq_o,
  input wire logic                rx_buf_take_i,
  input wire logic                rx_buf_valid_o,
  input wire logic [SDRAM_AW-1:0] rx_buf_addr_o,
  input wire logic                rx_pkt_push_i,
  input wire logic [ID_W-1:0]     rx_pkt_id_i,
  input wire logic                rx_pkt_oam_i,
  input wire logic                rx_pkt_drop_o,
  input wire logic [ID_W-1:0]     rx_pkt_drop_id_o,
  input wire logic                eth_tx_take_i,
  input wire logic                eth_tx_valid_o,
  input wire logic [SDRAM_AW-1:0] eth_tx_addr_o,
  input wire logic                line_tx_take_i,
  input wire logic                line_tx_valid_o,
  input wire logic [SDRAM_AW-1:0] line_tx_addr_o,
  input wire logic [TXBASE_W-1:0] tx_buf_base_i,
  input wire logic [SDRAM_AW-1:0] tx_head_addr_o,
  input wire logic [SDRAM_AW-1:0] tx_next_addr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ----------------------------
  // delivery, discard and lookup
  // ----------------------------
  rxbuf_cause_a:
  assert property (rx_buf_valid_o |-> $past(rx_buf_take_i) && rx_buf_addr_o[10:0] == LOW_ZEROS)
    else $error("bad receive delivery");
  ethout_cause_a:
  assert property (eth_tx_valid_o |-> $past(eth_tx_take_i) && eth_tx_addr_o[10:0] == LOW_ZEROS)
    else $error("bad eth-out delivery");
  lineout_cause_a:
  assert property (line_tx_valid_o |-> $past(line_tx_take_i) && line_tx_addr_o[10:0] == 11'h000)
    else $error("bad line-out delivery");
  drop_cause_a:
  assert property (rx_pkt_drop_o |-> $past(rx_pkt_push_i && !rx_pkt_oam_i)
                   && rx_pkt_drop_id_o == $past(rx_pkt_id_i))
    else $error("stray discard");
  oam_kept_a:
  assert property (rx_pkt_push_i && rx_pkt_oam_i |=> !rx_pkt_drop_o)
    else $error("oam packet discarded");
  head_format_a:
  assert property (1'h1 |=> tx_head_addr_o[23:20] == $past(tx_buf_base_i)
                   && tx_head_addr_o[10:0] == LOW_ZEROS)
    else $error("bad head address");
  next_format_a:
  assert property (1'h1 |=> {tx_next_addr_o[23:20], tx_next_addr_o[10:0]}
                   == {$past(tx_buf_base_i), LOW_ZEROS})
    else $error("bad next address");
  // ----------------------------
  // host port
  // ----------------------------
  irq_masked_a:
  assert property (host_wr_i && host_bus_width_select_i && host_addr_i == QUEUE_BASE + OFS_MASK
                   && host_wdata_i[5:0] == 6'h3F |-> ##2 !irq_o)
    else $error("irq not masked");
  pop_upper_a:
  assert property (host_rd_i && host_bus_width_select_i
                   && host_addr_i == QUEUE_BASE + OFS_HOSTQ_POP |=> host_rdata_o[31:13] == 19'h0)
    else $error("pop upper bits set");
endmodule
bind cbqm_queue_manager cbqm_properties u_props (.*);

// ==== sim/test_cpu_buffer_queue_manager.sv ====
/* test_cpu_buffer_queue_manager: random and corner traffic.
   Assumes cbqm_pkg and the checker compiled first. */
`timescale 1ns/100ps
module test_cpu_buffer_queue_manager
  import cbqm_pkg::*;
;
  logic        clk_sys_i = 1'h0, srst_i, host_bus_width_select_i, host_wr_i, host_rd_i;
  logic        irq_o, rx_buf_take_i, rx_buf_valid_o, rx_pkt_push_i, rx_pkt_oam_i;
  logic        rx_pkt_drop_o, eth_tx_take_i, eth_tx_valid_o, line_tx_take_i, line_tx_valid_o;
  logic        sent_ret_push_i, recv_ret_push_i, tx_head_valid_o;
  logic [17:0] host_addr_i;
  logic [31:0] host_wdata_i, host_rdata_o, d;
  logic [12:0] rx_pkt_id_i, rx_pkt_drop_id_o, sent_ret_id_i, recv_ret_id_i;
  logic [23:0] rx_buf_addr_o, eth_tx_addr_o, line_tx_addr_o, tx_head_addr_o, tx_next_addr_o;
  logic [3:0]  tx_buf_base_i;
  logic [5:0]  tx_bundle_i;
  logic [8:0]  tx_buf_i;
  logic [12:0] mq[$];
  int          failures = 0, comparisons = 0;

  cbqm_queue_manager dut (.*);
  always #50 clk_sys_i = ~clk_sys_i;

  // ----------------------------
  // bus and engine tasks
  // ----------------------------
  function automatic logic [17:0] qa(input logic [17:0] ofs);
    return QUEUE_BASE + ofs + (host_bus_width_select_i ? 18'h0 : ALT16_STEP);
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    {host_addr_i, host_wdata_i, host_wr_i} <= {a, v, 1'h1};
    @(posedge clk_sys_i);
    host_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] x);
    @(posedge clk_sys_i);
    {host_addr_i, host_rd_i} <= {a, 1'h1};
    @(posedge clk_sys_i);
    host_rd_i <= 1'h0;
    #1 chk(host_rdata_o, x);
  endtask
  task automatic take(input int q, input logic [12:0] id);
    @(posedge clk_sys_i);
    {line_tx_take_i, eth_tx_take_i, rx_buf_take_i} <= 3'h1 << q;
    @(posedge clk_sys_i);
    {line_tx_take_i, eth_tx_take_i, rx_buf_take_i} <= 3'h0;
    #1 chk(q == 0 ? {rx_buf_valid_o, rx_buf_addr_o} : q == 1 ? {eth_tx_valid_o, eth_tx_addr_o}
           : {line_tx_valid_o, line_tx_addr_o}, {1'h1, id, LOW_ZEROS});
  endtask
  // push on engine q, then check the discard pulse
  task automatic push(input int q, input logic [12:0] id, input logic oam, input logic drop);
    @(posedge clk_sys_i);
    {recv_ret_push_i, sent_ret_push_i, rx_pkt_push_i} <= 3'h1 << q;
    {rx_pkt_id_i, sent_ret_id_i, recv_ret_id_i, rx_pkt_oam_i} <= {id, id, id, oam};
    @(posedge clk_sys_i);
    {recv_ret_push_i, sent_ret_push_i, rx_pkt_push_i} <= 3'h0;
    #1 chk({rx_pkt_drop_o, drop ? rx_pkt_drop_id_o : id}, {drop, id});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    print_verdict();
  end

  // ----------------------------
  // main sequence
  // ----------------------------
  initial begin
    {srst_i, host_bus_width_select_i, host_wr_i, host_rd_i, rx_buf_take_i} = 5'h18;
    {rx_pkt_push_i, rx_pkt_oam_i, eth_tx_take_i, line_tx_take_i} = '0;
    {sent_ret_push_i, recv_ret_push_i, host_addr_i, host_wdata_i} = '0;
    {rx_pkt_id_i, sent_ret_id_i, recv_ret_id_i, tx_buf_base_i, tx_bundle_i, tx_buf_i} = '0;
    void'($urandom(2404));
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk(irq_o, 1'h1);
    rd(qa(OFS_CHANGE), 32'h3F);
    for (int i = 7; i < 30; i++) if (i != 16) rd(qa(18'(4 * i)), 32'h0);
    wr(qa(OFS_MASK), 32'h3F);
    @(posedge clk_sys_i) #1 chk(irq_o, 1'h0);
    wr(qa(OFS_CHANGE), 32'h3F);
    wr(qa(OFS_MASK), 32'h0);
    // random upper bits must be ignored
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      mq.push_back(d[12:0]);
      wr(qa(OFS_POOL_INS), d);
    end
    rd(qa(OFS_POOL_LVL), 32'h4);
    take(0, mq.pop_front());
    wr(qa(OFS_HOSTQ_THR), 32'h2);
    wr(qa(OFS_CHANGE), 32'h3F);
    wr(qa(OFS_POOL_THR), 32'h3);
    d = $urandom;
    push(0, d[12:0], 1'h0, 1'h1);
    push(0, d[25:13], 1'h1, 1'h0);
    wr(qa(OFS_POOL_THR), 32'h2);
    push(0, d[12:0] ^ 13'h1555, 1'h0, 1'h0);
    rd(qa(OFS_CHANGE), 32'h3);
    rd(qa(OFS_HOSTQ_LVL), 32'h2);
    rd(qa(OFS_HOSTQ_POP), {19'h0, d[25:13]});
    rd(qa(OFS_HOSTQ_POP), {19'h0, d[12:0] ^ 13'h1555});
    rd(qa(OFS_HOSTQ_POP), 32'h0);
    for (int q = 1; q < 3; q++) begin
      mq.delete();
      for (int i = 0; i < 3; i++) begin
        d = $urandom;
        mq.push_back(d[12:0]);
        wr(qa(q == 1 ? OFS_ETHO_INS : OFS_LINE_INS), d);
      end
      rd(qa(q == 1 ? OFS_ETHO_LVL : OFS_LINE_LVL), 32'h3);
      if (q == 1) wr(qa(OFS_ETHO_THR), 32'h2);
      wr(qa(OFS_CHANGE), 32'h3F);
      take(q, mq.pop_front());
      if (q == 1) rd(qa(OFS_CHANGE), 32'h4);
      while (mq.size() > 0) take(q, mq.pop_front());
    end
    wr(qa(OFS_SENT_THR), 32'h2);
    wr(qa(OFS_CHANGE), 32'h3F);
    for (int q = 1; q < 3; q++) begin
      mq.delete();
      // one push beyond full must be dropped
      for (int i = 0; i < 33; i++) begin
        d = $urandom;
        if (i < SHALLOW_DEPTH) mq.push_back(d[12:0]);
        push(q, d[12:0], 1'h0, 1'h0);
      end
      rd(qa(q == 1 ? OFS_SENT_LVL : OFS_RECV_LVL), 32'h20);
      if (q == 1) rd(qa(OFS_CHANGE), 32'h10);
      while (mq.size() > 0) rd(qa(q == 1 ? OFS_SENT_POP : OFS_RECV_POP), mq.pop_front());
    end
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      wr(LIST_BASE + {d[8:0], 2'h0}, {23'h0, d[17:9]});
      wr(HEAD_BASE + {d[23:18], 2'h0}, {22'h0, d[24], d[8:0]});
      @(posedge clk_sys_i);
      {tx_buf_base_i, tx_bundle_i, tx_buf_i} <= {d[28:25], d[23:18], d[8:0]};
      repeat (2) @(posedge clk_sys_i);
      #1 chk({tx_head_valid_o, tx_head_addr_o, tx_next_addr_o},
             {d[24], d[28:25], d[8:0], LOW_ZEROS, d[28:25], d[17:9], LOW_ZEROS});
      rd(HEAD_BASE + {d[23:18], 2'h0}, {22'h0, d[24], d[8:0]});
    end
    @(posedge clk_sys_i) host_bus_width_select_i <= 1'h0;
    #1 wr(qa(OFS_POOL_INS), $urandom);
    rd(qa(OFS_POOL_LVL), 32'h4);
    print_verdict();
  end
endmodule
